// file: include/vsc_pkg.sv
// vsc_pkg: constants and types for the voltage supervisor control block.
// assumes a single core_clk domain; tick and comparator arrive as pins.
package vsc_pkg;
   // run mode select codes that permit supervisor operation
   localparam logic [1:0] RUN_MODE_SUP_A   = 2'h2;
   localparam logic [1:0] RUN_MODE_SUP_B   = 2'h3;
   // action select encodings
   localparam logic [1:0] ACT_NONE         = 2'h0;
   localparam logic [1:0] ACT_RESET        = 2'h1;
   localparam logic [1:0] ACT_IRQ          = 2'h2;
   localparam logic [1:0] ACT_RESET_ALT    = 2'h3;
   // settle times in tick periods
   localparam int         SETTLE_TICKS     = 4;
   localparam int         SAMPLE_EXTRA     = 2;
   localparam int         TICK_CNT_W       = 3;
   // cpu hold after reset release, in low speed clock cycles
   localparam int         CPU_HOLD_CYCLES  = 128;
   localparam int         HOLD_CNT_W       = 8;
   localparam logic       RST_FLAG         = 1'b0;

   typedef enum logic [1:0] {
      VSC_OFF,
      VSC_SETTLE,
      VSC_READY
   } vsc_state_t;
endpackage

// file: include/vsc_sync_if.sv
// vsc_sync_if: synchronised pin levels between the synchroniser and the top.
// assumes both ends run on core_clk.
`timescale 1ns/1ps
interface vsc_sync_if;
   logic tick_lvl;   // synchronised slow tick level
   logic below_lvl;  // synchronised comparator: supply below fall threshold
   logic above_lvl;  // synchronised comparator: supply above rise threshold
   modport src (output tick_lvl, output below_lvl, output above_lvl);
   modport dst (input tick_lvl, input below_lvl, input above_lvl);
endinterface

// file: logic/vsc_sync.sv
// vsc_sync: two-flop synchronisers for the asynchronous pin inputs.
// assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
module vsc_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic core_clk,   // block clock
   input  wire logic arst_n,     // async reset, active low
   input  wire logic tick_pin,   // raw slow tick
   input  wire logic below_pin,  // raw comparator fall output
   input  wire logic above_pin,  // raw comparator rise output
   vsc_sync_if.src   sync        // synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stab_q;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         stab_q <= '0;
      end else begin
         meta_q <= {above_pin, below_pin, tick_pin};
         stab_q <= meta_q;
      end
   end

   assign sync.tick_lvl  = stab_q[0];
   assign sync.below_lvl = stab_q[1];
   assign sync.above_lvl = stab_q[2];
endmodule

// file: logic/vsc_top.sv
// vsc_top: supervisor control around a supply comparator.
// assumes comparator, tick and low speed clock are asynchronous pins;
// control bits come from the cpu as plain core_clk-domain ports.
// sample_select is expected to stay static while the supervisor is on.
//
// Function
// - supervisor runs when enabled with run mode code 10 or 11
// - valid flag rises after four ticks, six when sampling is selected
// - below flag, reset and interrupt stay masked until valid flag is set
// - judging continues after the valid flag is set
// - supply below fall threshold sets below flag and the enabled action
// - supply above rise threshold clears below flag and releases reset
// - cpu stays halted 128 low speed clock cycles after reset release
// - with sampling, below flag and action appear with the valid flag
// - with sampling, below flag updates only from tick-edge samples
// - with sampling, below flag, reset and interrupt hold while the tick is stopped
// - writing zero to enable turns the supervisor off
// - action select: 00 none, 01 reset, 10 interrupt, 11 reset
// - below flag clears when supervisor is switched on
// - sample select picks direct or tick-sampled detection
// - valid flag reads zero while off or judgment pending
`timescale 1ns/1ps
module vsc_top (
   input  wire logic       core_clk,           // 200 MHz block clock
   input  wire logic       arst_n,             // async reset, active low
   input  wire logic       supervisor_on,      // enable bit from cpu
   input  wire logic [1:0] run_mode_select,    // run mode field
   input  wire logic [1:0] action_select,      // action select field
   input  wire logic       sample_select,      // 1: tick-sampled detection
   input  wire logic       slow_tick_16k,      // 16 kHz tick pin
   input  wire logic       low_speed_clock,    // low speed clock pin
   input  wire logic       cmp_below,          // comparator: below fall
   input  wire logic       cmp_above,          // comparator: above rise
   output logic            result_valid_flag,  // judgment valid
   output logic            below_threshold_flag, // supply low
   output logic            sup_reset,          // supervisor reset out
   output logic            sup_irq,            // interrupt request level
   output logic            cpu_halt            // cpu held after reset
);
   ////////////////////////////////////////////////////////////////////////
   vsc_sync_if sync ();
   logic [1:0] lsc_sync_q;
   logic       lsc_prev_q;
   logic       tick_prev_q;
   logic       en_prev_q;

   vsc_sync #(.WIDTH(3)) u_sync (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .tick_pin  (slow_tick_16k),
      .below_pin (cmp_below),
      .above_pin (cmp_above),
      .sync      (sync)
   );

   // the low speed clock gets its own two flops; both edge detectors read
   // only second-stage levels, never the metastable first stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lsc_sync_q  <= '0;
         lsc_prev_q  <= 1'b0;
         tick_prev_q <= 1'b0;
         en_prev_q   <= 1'b0;
      end else begin
         lsc_sync_q  <= {lsc_sync_q[0], low_speed_clock};
         lsc_prev_q  <= lsc_sync_q[1];
         tick_prev_q <= sync.tick_lvl;
         en_prev_q   <= supervisor_on;
      end
   end

   logic tick_rise;
   logic lsc_rise;
   logic mode_ok;
   logic active;
   logic turn_on;
   assign tick_rise = sync.tick_lvl & ~tick_prev_q;
   assign lsc_rise  = lsc_sync_q[1] & ~lsc_prev_q;
   assign mode_ok   = (run_mode_select == vsc_pkg::RUN_MODE_SUP_A) ||
                      (run_mode_select == vsc_pkg::RUN_MODE_SUP_B);
   assign active    = supervisor_on & mode_ok;
   // enable edge rather than active edge, so a turn-on under a refused
   // mode still leaves the flag cleared for the next real start
   assign turn_on   = supervisor_on & ~en_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // settle sequencing
   // rises seen on the off-to-settle edge are not counted, so the first
   // counted rise is always at least one cycle after enable
   vsc_pkg::vsc_state_t         state_q;
   logic [vsc_pkg::TICK_CNT_W-1:0] tick_cnt_q;
   logic [vsc_pkg::TICK_CNT_W-1:0] settle_target;
   assign settle_target = sample_select ?
      vsc_pkg::TICK_CNT_W'(vsc_pkg::SETTLE_TICKS + vsc_pkg::SAMPLE_EXTRA) :
      vsc_pkg::TICK_CNT_W'(vsc_pkg::SETTLE_TICKS);

   logic settle_done;
   assign settle_done = (state_q == vsc_pkg::VSC_SETTLE) && tick_rise &&
                        (tick_cnt_q == settle_target - 3'h1);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= vsc_pkg::VSC_OFF;
         tick_cnt_q <= '0;
      end else if (!active) begin
         state_q    <= vsc_pkg::VSC_OFF;
         tick_cnt_q <= '0;
      end else begin
         unique case (state_q)
            vsc_pkg::VSC_OFF: begin
               state_q    <= vsc_pkg::VSC_SETTLE;
               tick_cnt_q <= '0;
            end
            vsc_pkg::VSC_SETTLE: begin
               if (settle_done) begin
                  state_q <= vsc_pkg::VSC_READY;
               end else if (tick_rise) begin
                  tick_cnt_q <= tick_cnt_q + 3'h1;
               end
            end
            vsc_pkg::VSC_READY: begin
               state_q <= vsc_pkg::VSC_READY;
            end
         endcase
      end
   end

   // valid rises on the settle_done edge itself, so the flag and the
   // enabled action can appear in that very cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_valid_flag <= 1'b0;
      end else begin
         // pending or off reads zero
         result_valid_flag <= active &&
            ((state_q == vsc_pkg::VSC_READY) || settle_done);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // judgment: direct uses the synchronised level every cycle, sampled
   // mode looks only on tick rises, so a stopped tick freezes the flag
   logic ready_now;
   logic judge_en;
   assign ready_now = (state_q == vsc_pkg::VSC_READY) || settle_done;
   assign judge_en  = sample_select ? tick_rise : 1'b1;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         below_threshold_flag <= vsc_pkg::RST_FLAG;
      end else if (!active || turn_on) begin
         below_threshold_flag <= 1'b0;
      end else if (ready_now && judge_en) begin
         // settle_done coincides with a tick rise in sampled mode
         // both comparator outputs low means inside hysteresis: hold
         if (sync.below_lvl) begin
            below_threshold_flag <= 1'b1;
         end else if (sync.above_lvl) begin
            below_threshold_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // actions follow the flag; masked until valid by flag construction
   logic want_reset;
   logic want_irq;
   assign want_reset = (action_select == vsc_pkg::ACT_RESET) ||
                       (action_select == vsc_pkg::ACT_RESET_ALT);
   assign want_irq   = (action_select == vsc_pkg::ACT_IRQ);

   logic flag_next_low;
   assign flag_next_low = active && !turn_on && ready_now && judge_en &&
                          sync.below_lvl;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sup_reset <= 1'b0;
         sup_irq   <= 1'b0;
      end else begin
         // the reset is released by the rise threshold, or as soon as the
         // supervisor goes inactive (enable cleared or run mode refused)
         if (flag_next_low && want_reset) begin
            sup_reset <= 1'b1;
         end else if (!active || (below_threshold_flag == 1'b0 &&
                      !flag_next_low && sup_reset && ready_now &&
                      judge_en && sync.above_lvl)) begin
            sup_reset <= 1'b0;
         end else if (sup_reset && ready_now && judge_en &&
                      sync.above_lvl && !sync.below_lvl) begin
            sup_reset <= 1'b0;
         end
         // irq is a plain level that follows the flag, cleared on its edge
         sup_irq <= (flag_next_low || (below_threshold_flag && active &&
                     !(ready_now && judge_en && sync.above_lvl))) &&
                    want_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu hold counter on low speed clock rises after reset release
   // the count restarts each time reset is reasserted, so a bouncing
   // supply always gets the full hold after its last release
   logic [vsc_pkg::HOLD_CNT_W-1:0] hold_cnt_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_cnt_q       <= '0;
         cpu_halt         <= 1'b0;
      end else begin
         if (sup_reset) begin
            cpu_halt   <= 1'b1;
            hold_cnt_q <= '0;
         end else if (cpu_halt && lsc_rise) begin
            if (hold_cnt_q == vsc_pkg::HOLD_CNT_W'(
                   vsc_pkg::CPU_HOLD_CYCLES - 1)) begin
               cpu_halt <= 1'b0;
            end else begin
               hold_cnt_q <= hold_cnt_q + 8'h01;
            end
         end
      end
   end
endmodule

// file: testbench/voltage_supervisor_control_bench.sv
// voltage_supervisor_control_bench: self-checking run of vsc_top.
// assumes vsc_supply_model on the pins and vsc_monitor bound to the top.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
module voltage_supervisor_control_bench;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        supervisor_on, sample_select, tick_run, supply_low;
   logic [1:0]  run_mode_select, action_select;
   logic        slow_tick_16k, low_speed_clock, cmp_below, cmp_above;
   logic        result_valid_flag, below_threshold_flag;
   logic        sup_reset, sup_irq, cpu_halt;
   logic [15:0] lf = 16'hECC3;
   int          n_fail = 0, checked = 0, tk_n, ls_n, i;
   vsc_top          u_dut (.*);
   vsc_supply_model u_sup (.*);
   always #2.5 core_clk = ~core_clk;
   always @(posedge slow_tick_16k) tk_n++;
   always @(posedge low_speed_clock) ls_n++;
   task automatic summarize;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return result_valid_flag;
         1: return below_threshold_flag;
         default: return cpu_halt;
      endcase
   endfunction
   task automatic wait_on(input int w, input logic v);
      int c;
      for (c = 0; sig(w) !== v; c++) begin
         if (c == 4000) begin
            n_fail++;
            summarize();
         end
         @(negedge core_clk);
      end
   endtask
   initial begin
      {supervisor_on, sample_select, supply_low, tick_run} = 4'h1;
      {run_mode_select, action_select} = 4'h0;
      step(2);
      arst_n = 1'b1;
      // every action code, direct and sampled, then one refused mode
      for (i = 0; i < 9; i++) begin
         lf = lfsr_next(lf);
         action_select = i[1:0];
         sample_select = i[2];
         run_mode_select = (i == 8) ? 2'h1 : {1'b1, lf[0]};
         supply_low = 1'b1;
         @(posedge slow_tick_16k);
         step(10);
         tk_n = 0;
         supervisor_on = 1'b1;
         if (i == 8) begin
            step(400);
            `CHK(result_valid_flag, 1'b0)
         end else begin
            wait_on(0, 1'b1);
            `CHK(tk_n, sample_select ? 6 : 4)
            `CHK(below_threshold_flag, 1'b1)
            `CHK(sup_reset, action_select[0])
            `CHK(sup_irq, action_select == vsc_pkg::ACT_IRQ)
            step(1);
            tick_run = !sample_select;
            supply_low = 1'b0;
            if (sample_select) begin
               step(120);
               `CHK(below_threshold_flag, 1'b1)
               tick_run = 1'b1;
            end
            wait_on(1, 1'b0);
            ls_n = 0;
            `CHK(sup_reset, 1'b0)
            wait_on(2, 1'b0);
            `CHK((ls_n >= 126 && ls_n <= 131) || !action_select[0], 1'b1)
         end
         step(1);
         supervisor_on = 1'b0;
         step(2);
         `CHK(result_valid_flag, 1'b0)
      end
      summarize();
   end
endmodule

// file: testbench/vsc_monitor.sv
// vsc_monitor: port-level assertions on vsc_top.
// assumes one core_clk domain; tick pin is watched raw, before sync.
`timescale 1ns/1ps
module vsc_monitor (
   input wire logic       core_clk,             // clock
   input wire logic       arst_n,               // reset
   input wire logic       supervisor_on,        // enable
   input wire logic [1:0] run_mode_select,      // mode
   input wire logic [1:0] action_select,        // action
   input wire logic       sample_select,        // sampling
   input wire logic       slow_tick_16k,        // tick pin
   input wire logic       low_speed_clock,      // lsc pin
   input wire logic       cmp_below,            // cmp fall
   input wire logic       cmp_above,            // cmp rise
   input wire logic       result_valid_flag,    // valid
   input wire logic       below_threshold_flag, // low flag
   input wire logic       sup_reset,            // reset out
   input wire logic       sup_irq,              // irq out
   input wire logic       cpu_halt              // halt out
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   logic tk_q;
   int   tk_n, q_n, need;
   assign need = sample_select ? 6 : 4;
   // raw rises lead the synced ones, so bounds leave a few cycles slack
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tk_q <= 1'b0;
         tk_n <= 0;
         q_n  <= 0;
      end else begin
         tk_q <= slow_tick_16k;
         q_n  <= (slow_tick_16k && !tk_q) ? 0 : (q_n < 15) ? q_n + 1 : 15;
         if (!supervisor_on)
            tk_n <= 0;
         else if (slow_tick_16k && !tk_q && tk_n < 7)
            tk_n <= tk_n + 1;
      end
   end
   mask_out_a: assert property (!result_valid_flag |->
      !below_threshold_flag && !sup_reset && !sup_irq) else $error("early");
   off_clear_a: assert property (
      !(supervisor_on && run_mode_select[1]) |=> !result_valid_flag &&
      !below_threshold_flag && !sup_reset) else $error("not off");
   valid_early_a: assert property ($rose(result_valid_flag) |->
      tk_n >= need) else $error("valid too soon");
   valid_late_a: assert property (supervisor_on && run_mode_select[1] &&
      tk_n > need |-> result_valid_flag) else $error("valid missing");
   irq_sel_a: assert property (sup_irq |-> below_threshold_flag &&
      action_select == vsc_pkg::ACT_IRQ) else $error("bad irq");
   reset_sel_a: assert property ($rose(sup_reset) |->
      action_select[0] && below_threshold_flag) else $error("bad reset");
   halt_hold_a: assert property (sup_reset |=> cpu_halt)
      else $error("cpu not held");
   quiet_hold_a: assert property (sample_select && supervisor_on &&
      q_n == 15 |-> $stable(below_threshold_flag)) else $error("no tick");
   cover property ($rose(result_valid_flag) && sample_select);
   cover property ($rose(sup_irq));
   cover property ($fell(cpu_halt));
endmodule
////////////////////////////////////////////////////////////////////////////
bind vsc_top vsc_monitor u_mon (.*);

// file: testbench/vsc_supply_model.sv
// vsc_supply_model: tick, low speed clock and comparator pins.
// assumes the bench drives tick_run and supply_low just after core_clk.
`timescale 1ns/1ps
module vsc_supply_model (
   input  wire logic core_clk,        // clock
   input  wire logic tick_run,        // 0 stops the tick
   input  wire logic supply_low,      // supply below threshold
   output logic      slow_tick_16k,   // 40 core_clk period
   output logic      low_speed_clock, // free running, own phase
   output logic      cmp_below,       // supply low
   output logic      cmp_above        // supply recovered
);
   int ph = 0;
   initial slow_tick_16k = 1'b0;
   initial low_speed_clock = 1'b0;
   always #7.3 low_speed_clock = ~low_speed_clock;
   // a stopped oscillator freezes at its level, it does not idle low
   always @(posedge core_clk) begin
      ph <= tick_run ? (ph + 1) % 40 : ph;
      slow_tick_16k <= #1 (ph >= 20);
   end
   assign cmp_below = supply_low;
   assign cmp_above = !supply_low;
endmodule
